// ### verilog/dric_chain.sv
/*
 * Master reset, CPU bus gating, alternate input-pin roles and the daisy-chain
 * interrupt acknowledge logic of a dual serial controller.
 * Assumes a synchronous strobe-style CPU port (cs_n, rd_n, wr_n low active) and
 * that the serial channels and timer sit outside, steered by the outputs here.
 */
// Functional notes
// - Reset clears status, int status, mask, output port, config; vector becomes 0F.
// - Reset halts the counter/timer and drives all eight general outputs high.
// - Reset idles both channels with serial outputs held high.
// - Data bus floats while chip select high; transfers only with it low.
// - In chain mode the acknowledge cycle drives the bus regardless of chip select.
// - Input 2 is general input or, if configured, the timer external clock.
// - Outside chain mode input 6 is general input or channel B receive clock.
// - Outside chain mode input 5 is general input or channel B transmit clock.
// - Outside chain mode input 4 is general input or channel A receive clock.
// - Chain enable output sits high except for chain-input or own-request cases.
// - In chain mode chain input low forces chain output low; it returns high with the input.
// - After own request, chain output stays low until the end-of-interrupt command.
// - In chain mode requests reach the CPU only while chain input high; otherwise suppressed.
`default_nettype none
module dric_chain
   import dric_pkg::*;
(
   input  wire logic                        mclk_i,
   input  wire logic                        rst_i,
   input  wire logic                        chain_mode_i,
   input  wire logic                        cs_n_i,
   input  wire logic                        rd_n_i,
   input  wire logic                        wr_n_i,
   input  wire logic [dric_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [dric_pkg::DATA_W-1:0] data_i,
   output logic      [dric_pkg::DATA_W-1:0] data_o,
   output logic                             data_oe_n_o,
   input  wire logic [7:0]                  chan_status_i,
   input  wire logic [7:0]                  int_event_i,
   input  wire logic                        general_input_2_i,
   input  wire logic                        general_input_4_i,
   input  wire logic                        general_input_5_i,
   input  wire logic                        general_input_6_i,
   input  wire logic                        int_acknowledge_n_i,
   input  wire logic                        chain_enable_in_i,
   output logic                             chain_enable_out_o,
   output logic                             int_request_n_o,
   output logic [7:0]                       general_outputs_o,
   output logic                             timer_run_o,
   output logic                             timer_ext_clock_o,
   output logic                             chan_b_rx_ext_clock_o,
   output logic                             chan_b_tx_ext_clock_o,
   output logic                             chan_a_rx_ext_clock_o,
   output logic                             chan_active_o,
   output logic                             chan_a_serial_out_o,
   output logic                             chan_b_serial_out_o
);
   import dric_pkg::*;

   // =========================================================
   // Input synchronisation
   // Reset release is re-timed so control state leaves reset on a clean edge.
   logic [2:0] sync_q;
   logic       rst_sync;
   logic       ack_n_s;
   logic       ien_s;
   dric_sync #(.W(3), .INIT(3'b111)) u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .d_i    ({1'b0, int_acknowledge_n_i, chain_enable_in_i}),
      .q_o    (sync_q)
   );
   assign rst_sync = sync_q[2];
   assign ack_n_s  = sync_q[1];
   assign ien_s    = sync_q[0];

   // =========================================================
   // Registers
   logic [7:0] channel_status_reg,     channel_status_next;
   logic [7:0] interrupt_status_reg,   interrupt_status_next;
   logic [7:0] interrupt_mask_reg,     interrupt_mask_next;
   logic [7:0] output_port_reg,        output_port_next;
   logic [7:0] output_port_config_reg, output_port_config_next;
   logic [7:0] interrupt_vector_reg,   interrupt_vector_next;
   logic       wr_d_reg,               wr_d_next;
   logic       eoi;
   logic       wr_edge;

   always_comb begin
      wr_d_next               = ~wr_n_i & ~cs_n_i;
      wr_edge                 = wr_d_next & ~wr_d_reg & ~rst_sync;
      channel_status_next     = chan_status_i;
      interrupt_status_next   = interrupt_status_reg | int_event_i;
      interrupt_mask_next     = interrupt_mask_reg;
      output_port_next        = output_port_reg;
      output_port_config_next = output_port_config_reg;
      interrupt_vector_next   = interrupt_vector_reg;
      eoi                     = 1'b0;
      if (wr_edge) begin
         unique case (addr_i)
            ADDR_INT_STAT_MASK: interrupt_mask_next     = data_i;
            ADDR_VECTOR:        interrupt_vector_next   = data_i;
            ADDR_PORT_CFG:      output_port_config_next = data_i;
            ADDR_OP_SET:        output_port_next        = output_port_reg | data_i;
            ADDR_OP_CLR:        output_port_next        = output_port_reg & ~data_i;
            ADDR_STATUS:        interrupt_status_next   = (interrupt_status_reg & ~data_i) | int_event_i;
            ADDR_EOI:           eoi                     = 1'b1;
            default:            eoi                     = 1'b0;
         endcase
      end
      if (rst_sync) begin
         channel_status_next     = CLEAR_RESET;
         interrupt_status_next   = CLEAR_RESET;
         interrupt_mask_next     = CLEAR_RESET;
         output_port_next        = CLEAR_RESET;
         output_port_config_next = CLEAR_RESET;
         interrupt_vector_next   = VECTOR_RESET;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         channel_status_reg     <= CLEAR_RESET;
         interrupt_status_reg   <= CLEAR_RESET;
         interrupt_mask_reg     <= CLEAR_RESET;
         output_port_reg        <= CLEAR_RESET;
         output_port_config_reg <= CLEAR_RESET;
         interrupt_vector_reg   <= VECTOR_RESET;
         wr_d_reg               <= 1'b0;
      end else begin
         channel_status_reg     <= channel_status_next;
         interrupt_status_reg   <= interrupt_status_next;
         interrupt_mask_reg     <= interrupt_mask_next;
         output_port_reg        <= output_port_next;
         output_port_config_reg <= output_port_config_next;
         interrupt_vector_reg   <= interrupt_vector_next;
         wr_d_reg               <= wr_d_next;
      end
   end

   // =========================================================
   // Daisy chain
   // Acknowledge arms the reads that follow; each returns the vector until the end-of-interrupt command.
   dric_chain_t state_reg, state_next;
   logic        pending;
   logic        ien_out_next, irq_n_next;
   logic        ack_rd;

   always_comb begin
      pending      = |(interrupt_status_reg & interrupt_mask_reg);
      ack_rd       = chain_mode_i & ~rd_n_i;
      state_next   = state_reg;
      unique case (state_reg)
         DRIC_IDLE: if (chain_mode_i & pending & ien_s) state_next = DRIC_SERV;
         DRIC_SERV: begin
            if (!ack_n_s) state_next = DRIC_ACK;
            else if (eoi) state_next = DRIC_IDLE;
         end
         DRIC_ACK:  if (eoi) state_next = DRIC_IDLE;
         default:   state_next = DRIC_IDLE;
      endcase
      if (!chain_mode_i || rst_sync) state_next = DRIC_IDLE;
      // Request drops once nothing unmasked is pending, so a cleared source requests again only after a new event
      irq_n_next   = ~((state_next != DRIC_IDLE) & pending & ien_s & ack_n_s);
      if (!chain_mode_i) irq_n_next = ~pending;
      ien_out_next = ien_s & (state_next == DRIC_IDLE);
      if (!chain_mode_i) ien_out_next = 1'b1;
   end

   // =========================================================
   // Data bus and pin outputs
   logic [7:0] data_next;
   logic       oe_n_next;
   logic       ivec_cycle;

   always_comb begin
      ivec_cycle = ack_rd & (state_reg == DRIC_ACK);
      oe_n_next  = 1'b1;
      data_next  = 8'h00;
      if (ivec_cycle) begin
         oe_n_next = 1'b0;
         data_next = interrupt_vector_reg;
      end else if (!cs_n_i && !rd_n_i) begin
         oe_n_next = 1'b0;
         unique case (addr_i)
            ADDR_STATUS:        data_next = channel_status_reg;
            ADDR_INT_STAT_MASK: data_next = interrupt_status_reg;
            ADDR_VECTOR:        data_next = interrupt_vector_reg;
            ADDR_PORT_CFG:      data_next = output_port_config_reg;
            default:            data_next = 8'h00;
         endcase
      end
      if (rst_sync) oe_n_next = 1'b1;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg             <= DRIC_IDLE;
         int_request_n_o       <= 1'b1;
         chain_enable_out_o    <= 1'b1;
         data_o                <= 8'h00;
         data_oe_n_o           <= 1'b1;
         general_outputs_o     <= GPO_RESET;
         timer_run_o           <= 1'b0;
         timer_ext_clock_o     <= 1'b0;
         chan_b_rx_ext_clock_o <= 1'b0;
         chan_b_tx_ext_clock_o <= 1'b0;
         chan_a_rx_ext_clock_o <= 1'b0;
         chan_active_o         <= 1'b0;
         chan_a_serial_out_o   <= 1'b1;
         chan_b_serial_out_o   <= 1'b1;
      end else begin
         state_reg             <= state_next;
         int_request_n_o       <= irq_n_next;
         chain_enable_out_o    <= ien_out_next;
         data_o                <= data_next;
         data_oe_n_o           <= oe_n_next;
         // Pins are the complement of the output port latch
         general_outputs_o     <= rst_sync ? GPO_RESET : ~output_port_next;
         timer_run_o           <= ~rst_sync;
         timer_ext_clock_o     <= output_port_config_reg[CFG_TIMER_EXT] & general_input_2_i;
         chan_b_rx_ext_clock_o <= ~chain_mode_i & output_port_config_reg[CFG_RXB_EXT]
                                  & general_input_6_i;
         chan_b_tx_ext_clock_o <= ~chain_mode_i & output_port_config_reg[CFG_TXB_EXT]
                                  & general_input_5_i;
         chan_a_rx_ext_clock_o <= ~chain_mode_i & output_port_config_reg[CFG_RXA_EXT]
                                  & general_input_4_i;
         chan_active_o         <= ~rst_sync;
         chan_a_serial_out_o   <= 1'b1;
         chan_b_serial_out_o   <= 1'b1;
      end
   end

   // =========================================================
   // Assertions
   property p_rst_values;
      @(posedge mclk_i) disable iff (rst_i) rst_sync |=> interrupt_vector_reg == VECTOR_RESET
         && interrupt_mask_reg == 8'h00 && output_port_config_reg == 8'h00;
   endproperty
   a_rst_values: assert property (p_rst_values) else $error("reset values wrong");
   property p_rst_gpo;
      @(posedge mclk_i) disable iff (rst_i) rst_sync |=> general_outputs_o == GPO_RESET && !timer_run_o;
   endproperty
   a_rst_gpo: assert property (p_rst_gpo) else $error("outputs not high in reset");
   property p_mark;
      @(posedge mclk_i) disable iff (rst_i) chan_a_serial_out_o && chan_b_serial_out_o;
   endproperty
   a_mark: assert property (p_mark) else $error("serial out not marking");
   property p_float;
      @(posedge mclk_i) disable iff (rst_i) (cs_n_i && !ivec_cycle) |=> data_oe_n_o;
   endproperty
   a_float: assert property (p_float) else $error("bus driven without select");
   property p_vec;
      @(posedge mclk_i) disable iff (rst_i) ivec_cycle && !rst_sync |=> !data_oe_n_o
         && data_o == $past(interrupt_vector_reg);
   endproperty
   a_vec: assert property (p_vec) else $error("vector not driven");
   property p_ieo_in;
      @(posedge mclk_i) disable iff (rst_i) !ien_s |=> !chain_enable_out_o;
   endproperty
   a_ieo_in: assert property (p_ieo_in) else $error("chain out high with input low");
   property p_ieo_req;
      @(posedge mclk_i) disable iff (rst_i) !int_request_n_o && chain_mode_i |-> !chain_enable_out_o;
   endproperty
   a_ieo_req: assert property (p_ieo_req) else $error("chain out high while requesting");
   property p_supp;
      @(posedge mclk_i) disable iff (rst_i) chain_mode_i && !ien_s && $past(chain_mode_i)
         |=> int_request_n_o;
   endproperty
   a_supp: assert property (p_supp) else $error("request not suppressed");
   c_ack: cover property (@(posedge mclk_i) disable iff (rst_i) ivec_cycle);
   c_req: cover property (@(posedge mclk_i) disable iff (rst_i) !int_request_n_o);
   c_eoi: cover property (@(posedge mclk_i) disable iff (rst_i) state_reg == DRIC_ACK ##1 state_reg == DRIC_IDLE);
endmodule : dric_chain
`default_nettype wire

// ### verilog/dric_pkg.sv
/*
 * Package for the reset and interrupt chain block: reset values, widths, register
 * addresses, config bit positions and the daisy-chain acknowledge states.
 * Assumes a single 250 MHz clock domain and an active-high asynchronous reset.
 */
`default_nettype none
package dric_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned ADDR_W          = 4;
   localparam logic [7:0]  VECTOR_RESET    = 8'h0f;
   localparam logic [7:0]  CLEAR_RESET     = 8'h00;
   localparam logic [7:0]  GPO_RESET       = 8'hff;
   // Register addresses on the four-bit address port
   localparam logic [3:0]  ADDR_STATUS     = 4'h1;
   localparam logic [3:0]  ADDR_INT_STAT_MASK = 4'h5;
   localparam logic [3:0]  ADDR_VECTOR     = 4'hc;
   localparam logic [3:0]  ADDR_PORT_CFG   = 4'hd;
   localparam logic [3:0]  ADDR_OP_SET     = 4'he;
   localparam logic [3:0]  ADDR_OP_CLR     = 4'hf;
   localparam logic [3:0]  ADDR_EOI        = 4'ha;
   // Output port configuration bit positions selecting alternate input roles
   localparam int unsigned CFG_TIMER_EXT   = 0;
   localparam int unsigned CFG_RXB_EXT     = 1;
   localparam int unsigned CFG_TXB_EXT     = 2;
   localparam int unsigned CFG_RXA_EXT     = 3;
   typedef enum logic [2:0] {
      DRIC_IDLE = 3'b001,
      DRIC_ACK  = 3'b010,
      DRIC_SERV = 3'b100
   } dric_chain_t;
endpackage : dric_pkg
`default_nettype wire

// ### verilog/dric_sync.sv
/*
 * Two-flop synchroniser, one generate lane per bit.
 * Assumes inputs may change at any time relative to mclk_i.
 */
`default_nettype none
module dric_sync #(
   parameter int unsigned       W      = 1,
   parameter logic [W-1:0]      INIT   = '0
) (
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   input  wire logic [W-1:0]    d_i,
   output logic      [W-1:0]    q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d_i;
      q_next    = meta_reg;
   end

   for (genvar i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            meta_reg[i] <= INIT[i];
            q_reg[i]    <= INIT[i];
         end else begin
            meta_reg[i] <= meta_next[i];
            q_reg[i]    <= q_next[i];
         end
      end
   end

   assign q_o = q_reg;
endmodule : dric_sync
`default_nettype wire

// ### tb/dric_host_model.sv
/*
 * Far side of the chain block: the upstream chain neighbour and the CPU's acknowledge.
 * Assumes the bench says when the CPU wishes to service a request.
 */
`default_nettype none
module dric_host_model (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic upstream_en_i,
   input  wire logic service_i,
   input  wire logic int_request_n_i,
   output logic      chain_enable_in_o,
   output logic      int_acknowledge_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ack_n_reg;
   logic ack_n_next;
   // ==========================================
   // Acknowledge
   // Answers only a live request, so the next bus cycle is the vector read
   always_comb begin
      ack_n_next = ack_n_reg;
      if (!service_i) begin
         ack_n_next = 1'b1;
      end else if (!int_request_n_i) begin
         ack_n_next = 1'b0;
      end
   end
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_n_reg <= 1'b1;
      end else begin
         ack_n_reg <= ack_n_next;
      end
   end
   assign int_acknowledge_n_o = ack_n_reg;
   assign chain_enable_in_o   = upstream_en_i;
endmodule : dric_host_model
`default_nettype wire

// ### tb/dric_chain_tb.sv
/*
 * Self-checking bench for the reset and interrupt chain block.
 * Assumes the design package and the host model are compiled first.
 */
`default_nettype none
module dric_chain_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dric_pkg::*;
   logic mclk_i = 1'b0, rst_i = 1'b1, mode = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, chan_status = 8'h00, int_event = 8'h00, gpo;
   logic g2 = 1'b0, g4 = 1'b0, g5 = 1'b0, g6 = 1'b0, upstream = 1'b1, service = 1'b0;
   logic oe_n, ack_n, cei, ceo, irq_n, t_run, tclk, rxb, txb, rxa, act, sa, sb;
   int failures = 0, comparisons = 0;
   always #2 mclk_i = ~mclk_i;
   dric_host_model i_host (.mclk_i(mclk_i), .rst_i(rst_i), .upstream_en_i(upstream), .service_i(service),
      .int_request_n_i(irq_n), .chain_enable_in_o(cei), .int_acknowledge_n_o(ack_n));
   dric_chain i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .chain_mode_i(mode), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_n_o(oe_n),
      .chan_status_i(chan_status), .int_event_i(int_event), .general_input_2_i(g2),
      .general_input_4_i(g4), .general_input_5_i(g5), .general_input_6_i(g6),
      .int_acknowledge_n_i(ack_n), .chain_enable_in_i(cei), .chain_enable_out_o(ceo),
      .int_request_n_o(irq_n), .general_outputs_o(gpo), .timer_run_o(t_run),
      .timer_ext_clock_o(tclk), .chan_b_rx_ext_clock_o(rxb), .chan_b_tx_ext_clock_o(txb),
      .chan_a_rx_ext_clock_o(rxa), .chan_active_o(act), .chan_a_serial_out_o(sa),
      .chan_b_serial_out_o(sb));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      cs_n <= 1'b0; wr_n <= 1'b0; addr <= a; wdata <= d;
      @(posedge mclk_i);
      cs_n <= 1'b1; wr_n <= 1'b1;
      @(posedge mclk_i);
   endtask : wr
   // Strobes held until the answer has been taken
   task automatic rd(input logic cs, input logic [3:0] a, input logic oe_exp, input logic [7:0] d_exp);
      @(posedge mclk_i);
      cs_n <= cs; rd_n <= 1'b0; addr <= a;
      @(posedge mclk_i);
      #1 chk({7'h0, oe_n}, {7'h0, oe_exp});
      if (!oe_exp) chk(rdata, d_exp);
      @(posedge mclk_i);
      cs_n <= 1'b1; rd_n <= 1'b1;
      @(posedge mclk_i);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : idle
   // ==========================================
   // Scenarios
   task automatic reset_state();
      chk(gpo, GPO_RESET);
      chk({4'h0, t_run, act, sa, sb}, 8'h03);
      chk({5'h0, oe_n, irq_n, ceo}, 8'h07);
   endtask : reset_state
   task automatic after_reset();
      rd(1'b0, ADDR_VECTOR, 1'b0, VECTOR_RESET);
      rd(1'b0, ADDR_INT_STAT_MASK, 1'b0, CLEAR_RESET);
      chk({6'h0, t_run, act}, 8'h03);
   endtask : after_reset
   task automatic bus_gating();
      chan_status <= 8'h3c;
      rd(1'b1, ADDR_STATUS, 1'b1, 8'h00);
      rd(1'b0, ADDR_STATUS, 1'b0, 8'h3c);
      wr(ADDR_OP_SET, 8'h05);
      wr(ADDR_VECTOR, 8'h33);
      rd(1'b0, ADDR_VECTOR, 1'b0, 8'h33);
      idle(2);
      chk(gpo, 8'hfa);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      idle(2);
      reset_state();
      @(posedge mclk_i);
      rst_i <= 1'b0;
      idle(4);
      after_reset();
      chk(gpo, GPO_RESET);
   endtask : bus_gating
   task automatic pins(input logic [7:0] cfg, input logic m, input logic lvl, input logic [3:0] exp);
      wr(ADDR_PORT_CFG, cfg);
      mode <= m; g2 <= lvl; g4 <= lvl; g5 <= lvl; g6 <= lvl;
      idle(4);
      chk({4'h0, tclk, rxb, txb, rxa}, {4'h0, exp});
   endtask : pins
   task automatic alt_pins();
      pins(8'h0f, 1'b0, 1'b1, 4'hf);
      pins(8'h0f, 1'b0, 1'b0, 4'h0);
      pins(8'h00, 1'b0, 1'b1, 4'h0);
      pins(8'h05, 1'b0, 1'b1, 4'ha);
      pins(8'h0f, 1'b1, 1'b1, 4'h8);
   endtask : alt_pins
   task automatic chain();
      @(posedge mclk_i);
      mode <= 1'b1;
      wr(ADDR_VECTOR, 8'h5a);
      wr(ADDR_INT_STAT_MASK, 8'h01);
      upstream <= 1'b0;
      idle(4);
      chk({6'h0, irq_n, ceo}, 8'h02);
      @(posedge mclk_i);
      int_event <= 8'h01;
      @(posedge mclk_i);
      int_event <= 8'h00;
      idle(6);
      chk({7'h0, irq_n}, 8'h01);
      @(posedge mclk_i);
      upstream <= 1'b1;
      idle(6);
      chk({6'h0, irq_n, ceo}, 8'h00);
      @(posedge mclk_i);
      service <= 1'b1;
      idle(5);
      rd(1'b1, ADDR_STATUS, 1'b0, 8'h5a);
      service <= 1'b0;
      wr(ADDR_STATUS, 8'h01);
      idle(3);
      chk({6'h0, irq_n, ceo}, 8'h02);
      wr(ADDR_EOI, 8'h00);
      idle(4);
      chk({6'h0, irq_n, ceo}, 8'h03);
      @(posedge mclk_i);
      upstream <= 1'b0;
      idle(4);
      chk({7'h0, ceo}, 8'h00);
      @(posedge mclk_i);
      upstream <= 1'b1;
      idle(4);
      chk({7'h0, ceo}, 8'h01);
   endtask : chain
   // ==========================================
   // Run control
   task automatic conclude();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (2) @(posedge mclk_i);
      #1 reset_state();
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      idle(4);
      after_reset();
      bus_gating();
      alt_pins();
      chain();
      conclude();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk_i);
      failures++;
      conclude();
   end
endmodule : dric_chain_tb
`default_nettype wire
